// >>> src/ueng_pkg.sv
////////////////////////////////////////////////////////////////////////
// Purpose: shared constants and types for the usb endpoint engine
// Assumes: byte-wide sram port, packet-level serial engine in front
// Notes  : one eight-byte descriptor slot per endpoint, two per address
////////////////////////////////////////////////////////////////////////
package ueng_pkg;
    // endpoint addressing and descriptor layout
    localparam int          EP_N       = 16;
    localparam int          DESC_N     = 7;
    localparam logic [2:0]  DESC_LAST  = 3'h6;
    localparam logic [2:0]  D_CTRL     = 3'h0;
    localparam logic [2:0]  D_PTR_LO   = 3'h3;
    localparam logic [2:0]  D_PTR_HI   = 3'h4;
    localparam logic [2:0]  D_CNT_LO   = 3'h5;
    localparam logic [2:0]  D_CNT_HI   = 3'h6;
    // control byte fields
    localparam int          CF_TYPE    = 6;
    localparam int          CF_MP      = 4;
    localparam int          CF_STALL   = 3;
    localparam int          CF_TGL     = 0;
    localparam int          MAXP_W     = 10;
    // completion queue
    localparam int          TCQ_DEPTH  = 8;
    localparam logic [3:0]  TCQ_FULL   = 4'h8;
    // bus idle time before suspend, and core clock rate
    localparam int          SUSP_US    = 3000;
    localparam int          CLK_MHZ    = 25;

    typedef enum logic [1:0] {
        XT_CTRL, XT_INT, XT_BULK, XT_ISO
    } ueng_xtype_t;

    typedef enum logic [1:0] {
        PID_OUT, PID_IN, PID_SETUP
    } ueng_pid_t;

    typedef struct packed {
        logic       valid;
        ueng_pid_t  kind;
        logic [3:0] ep;
    } ueng_tok_t;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic       empty;
        logic       data1;
        logic [7:0] data;
    } ueng_tx_t;

    typedef struct packed {
        logic valid;
        logic stall;
    } ueng_hs_t;

    typedef struct packed {
        logic [3:0] ep;
        logic       dir;
        logic       bank;
    } ueng_tc_t;
endpackage

// >>> src/ueng_core.sv
////////////////////////////////////////////////////////////////////////
// Purpose: usb device endpoint engine, descriptor and payload mover
// Assumes: serial engine hands over tokens and byte streams; sram ack
//          comes at least one cycle after request and only while asked
// Notes  : all endpoint state except bank bits lives in sram
//
// What this block does
// - full or low speed usb device
// - sixteen addresses, one in, one out each
// - per-address control, interrupt, bulk, isochronous type
// - per-endpoint max payload up to 1023 bytes
// - no local endpoint storage; descriptors in sram
// - engine fetches descriptor and moves payload bytes
// - ping-pong uses both endpoints in one direction
// - multi-packet splits payload without software action
// - completed transactions queued first in first out
// - suspend allows sleep, resume wakes system
// - usb clock choice independent of system clock
// - activity signals go to event routing
////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
`default_nettype none

module ueng_core
    import ueng_pkg::*;
#(
    parameter int unsigned SUSP_CYC = SUSP_US * CLK_MHZ
) (
    input  wire logic            core_clk,
    input  wire logic            sys_rst,
    input  wire logic            low_speed,
    input  wire logic [1:0]      clk_src_sel,
    input  wire logic [15:0]     desc_base,
    input  wire logic [EP_N-1:0] pp_en,
    input  wire ueng_tok_t       tok_i,
    input  wire logic            rx_valid,
    input  wire logic [7:0]      rx_data,
    input  wire logic            rx_end,
    output logic                 rx_ready,
    output ueng_tx_t             tx_o,
    input  wire logic            tx_ready,
    input  wire logic            in_ack,
    input  wire logic            in_fail,
    output ueng_hs_t             hs_o,
    output logic                 mem_req,
    output logic                 mem_we,
    output logic [15:0]          mem_addr,
    output logic [7:0]           mem_wdata,
    input  wire logic            mem_ack,
    input  wire logic [7:0]      mem_rdata,
    output logic                 tc_valid,
    output ueng_tc_t             tc_entry,
    input  wire logic            tc_pop,
    output logic                 evt_tc,
    output logic                 evt_setup,
    input  wire logic            line_idle,
    output logic                 sleep_ok,
    output logic                 wake,
    output logic                 link_ls,
    output logic [1:0]           usb_clk_sel
);

    typedef enum logic [2:0] {
        S_IDLE, S_FETCH, S_DEC, S_TXRD, S_TXSEND, S_WAITACK, S_RXW, S_WB
    } ueng_state_t;

    localparam logic [16:0] SUSP_LAST = 17'(SUSP_CYC - 1);

    ueng_state_t      st_r;
    ueng_tok_t        tok_r;
    logic             slot_r;
    logic [2:0]       idx_r;
    logic [9:0]       off_r;
    logic [7:0]       desc_r [DESC_N];
    logic [EP_N-1:0]  bank_r;
    logic             mem_req_r;
    logic             mem_we_r;
    logic [15:0]      mem_addr_r;
    logic [7:0]       mem_wdata_r;
    logic             rx_ready_r;
    ueng_tx_t         tx_r;
    ueng_hs_t         hs_r;
    logic             evt_tc_r;
    logic             evt_setup_r;
    ueng_tc_t         tcq_r [TCQ_DEPTH];
    logic [2:0]       tcq_wp_r;
    logic [2:0]       tcq_rp_r;
    logic [3:0]       tcq_cnt_r;
    logic             tc_valid_r;
    ueng_tc_t         tc_entry_r;
    logic [16:0]      idle_cnt_r;
    logic             sleep_ok_r;
    logic             wake_r;
    logic             link_ls_r;
    logic [1:0]       clk_sel_r;

    ////////////////////////////////////////////////////////////////////
    // descriptor field decode
    wire logic        ack      = mem_req_r & mem_ack;
    wire logic        is_in    = (tok_r.kind == PID_IN);
    wire logic        is_setup = (tok_r.kind == PID_SETUP);
    wire ueng_xtype_t xtype    = ueng_xtype_t'(desc_r[D_CTRL][CF_TYPE +: 2]);
    wire logic        is_iso   = (xtype == XT_ISO);
    wire logic        mp       = desc_r[D_CTRL][CF_MP];
    wire logic        stall    = desc_r[D_CTRL][CF_STALL];
    wire logic        tgl      = desc_r[D_CTRL][CF_TGL];
    wire logic [9:0]  maxp     = {desc_r[2][1:0], desc_r[1]};
    wire logic [15:0] ptr      = {desc_r[D_PTR_HI], desc_r[D_PTR_LO]};
    wire logic [9:0]  cnt      = {desc_r[D_CNT_HI][1:0], desc_r[D_CNT_LO]};

    // packet limit: in and multi-packet are bounded by what remains
    wire logic        use_cnt  = is_in | mp;
    wire logic [9:0]  lim      = (use_cnt && cnt < maxp) ? cnt : maxp;
    wire logic [9:0]  xfer     = is_in ? lim : off_r;
    wire logic        short_pk = (xfer < maxp);

    // write-back values; multi-packet walks the pointer forward
    wire logic [15:0] ptr_new  = mp ? ptr + {6'h00, xfer} : ptr;
    wire logic [9:0]  cnt_new  = mp ? cnt - xfer : (is_in ? cnt : off_r);
    wire logic        done     = !mp || short_pk || cnt_new == 10'h000;
    wire logic        tgl_new  = is_iso ? tgl : (is_setup | ~tgl);
    wire logic [7:0]  wb_data  =
        (idx_r == D_CTRL)   ? {desc_r[D_CTRL][7:1], tgl_new} :
        (idx_r == D_PTR_LO) ? ptr_new[7:0] :
        (idx_r == D_PTR_HI) ? ptr_new[15:8] :
        (idx_r == D_CNT_LO) ? cnt_new[7:0] :
        (idx_r == D_CNT_HI) ? {desc_r[D_CNT_HI][7:2], cnt_new[9:8]} :
                              desc_r[idx_r];

    // slot choice: ping-pong follows the bank bit, else the direction
    wire logic        tok_in   = (tok_i.kind == PID_IN);
    wire logic        slot_sel = pp_en[tok_i.ep] ? bank_r[tok_i.ep]
                                                 : tok_in;
    wire logic [15:0] desc_adr = desc_base
                                 + {8'h00, tok_r.ep, slot_r, idx_r};
    wire logic [15:0] data_adr = ptr + {6'h00, off_r};
    wire logic        wb_end   = (st_r == S_WB) && ack
                                 && (idx_r == DESC_LAST);
    wire logic        push     = wb_end && done;

    ////////////////////////////////////////////////////////////////////
    // transaction sequencer: fetch, move payload, write back
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r        <= S_IDLE;
            tok_r       <= '0;
            slot_r      <= 1'b0;
            idx_r       <= 3'h0;
            off_r       <= 10'h000;
            mem_req_r   <= 1'b0;
            mem_we_r    <= 1'b0;
            mem_addr_r  <= 16'h0000;
            mem_wdata_r <= 8'h00;
            rx_ready_r  <= 1'b0;
            tx_r        <= '0;
            hs_r        <= '0;
            evt_setup_r <= 1'b0;
        end else begin
            hs_r        <= '0;
            evt_setup_r <= 1'b0;
            if (ack) begin
                mem_req_r <= 1'b0;
            end
            case (st_r)
                S_IDLE: if (tok_i.valid) begin
                    tok_r       <= tok_i;
                    slot_r      <= slot_sel;
                    idx_r       <= 3'h0;
                    off_r       <= 10'h000;
                    evt_setup_r <= (tok_i.kind == PID_SETUP);
                    st_r        <= S_FETCH;
                end
                S_FETCH: begin
                    if (!mem_req_r) begin
                        mem_req_r  <= 1'b1;
                        mem_we_r   <= 1'b0;
                        mem_addr_r <= desc_adr;
                    end
                    if (ack) begin
                        idx_r <= idx_r + 3'h1;
                        if (idx_r == DESC_LAST) begin
                            idx_r <= 3'h0;
                            st_r  <= S_DEC;
                        end
                    end
                end
                // a stalled endpoint refuses all but setup
                S_DEC: if (stall && !is_setup) begin
                    hs_r <= '{valid: 1'b1, stall: 1'b1};
                    st_r <= S_IDLE;
                end else if (!is_in) begin
                    rx_ready_r <= 1'b1;
                    st_r       <= S_RXW;
                end else if (lim == 10'h000) begin
                    tx_r <= '{valid: 1'b1, last: 1'b1, empty: 1'b1,
                              data1: tgl, data: 8'h00};
                    st_r <= S_TXSEND;
                end else begin
                    st_r <= S_TXRD;
                end
                S_TXRD: begin
                    if (!mem_req_r) begin
                        mem_req_r  <= 1'b1;
                        mem_we_r   <= 1'b0;
                        mem_addr_r <= data_adr;
                    end
                    if (ack) begin
                        tx_r <= '{valid: 1'b1,
                                  last: (off_r + 10'h001) == lim,
                                  empty: 1'b0, data1: tgl,
                                  data: mem_rdata};
                        st_r <= S_TXSEND;
                    end
                end
                S_TXSEND: if (tx_ready) begin
                    tx_r.valid <= 1'b0;
                    off_r      <= off_r + 10'h001;
                    if (!tx_r.last) begin
                        st_r <= S_TXRD;
                    end else if (is_iso) begin
                        st_r <= S_WB;
                    end else begin
                        st_r <= S_WAITACK;
                    end
                end
                S_WAITACK: if (in_ack) begin
                    st_r <= S_WB;
                end else if (in_fail) begin
                    st_r <= S_IDLE;
                end
                // bytes past the limit are taken and dropped
                S_RXW: begin
                    if (rx_valid && rx_ready_r) begin
                        if (off_r < lim) begin
                            rx_ready_r  <= 1'b0;
                            mem_req_r   <= 1'b1;
                            mem_we_r    <= 1'b1;
                            mem_addr_r  <= data_adr;
                            mem_wdata_r <= rx_data;
                        end
                    end else if (rx_end && rx_ready_r) begin
                        rx_ready_r <= 1'b0;
                        hs_r       <= '{valid: !is_iso, stall: 1'b0};
                        st_r       <= S_WB;
                    end
                    if (ack) begin
                        rx_ready_r <= 1'b1;
                        off_r      <= off_r + 10'h001;
                    end
                end
                S_WB: begin
                    if (!mem_req_r) begin
                        mem_req_r   <= 1'b1;
                        mem_we_r    <= 1'b1;
                        mem_addr_r  <= desc_adr;
                        mem_wdata_r <= wb_data;
                    end
                    if (ack) begin
                        idx_r <= idx_r + 3'h1;
                        if (idx_r == DESC_LAST) begin
                            st_r <= S_IDLE;
                        end
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // descriptor copy is plain data, so it carries no reset
    always_ff @(posedge core_clk) begin
        if (st_r == S_FETCH && ack) begin
            desc_r[idx_r] <= mem_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bank bits and completion events
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bank_r   <= '0;
            evt_tc_r <= 1'b0;
        end else begin
            evt_tc_r <= push;
            if (wb_end && pp_en[tok_r.ep]) begin
                bank_r[tok_r.ep] <= ~bank_r[tok_r.ep];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // completion queue; head is registered so outputs stay clean
    wire logic       tc_pop_ok = tc_pop & tc_valid_r;
    wire logic       push_ok   = push & (tcq_cnt_r != TCQ_FULL | tc_pop_ok);
    wire ueng_tc_t   tc_new    = '{ep: tok_r.ep, dir: is_in, bank: slot_r};
    wire logic [2:0] rp_nxt    = tcq_rp_r + {2'h0, tc_pop_ok};
    wire logic [3:0] cnt_nxt   = tcq_cnt_r + {3'h0, push_ok}
                                 - {3'h0, tc_pop_ok};
    wire logic       to_empty  = (tcq_cnt_r == {3'h0, tc_pop_ok});
    wire ueng_tc_t   head_nxt  = (push_ok && to_empty) ? tc_new
                                                       : tcq_r[rp_nxt];

    always_ff @(posedge core_clk) begin
        if (push_ok) begin
            tcq_r[tcq_wp_r] <= tc_new;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tcq_wp_r   <= 3'h0;
            tcq_rp_r   <= 3'h0;
            tcq_cnt_r  <= 4'h0;
            tc_valid_r <= 1'b0;
            tc_entry_r <= '0;
        end else begin
            tcq_wp_r   <= tcq_wp_r + {2'h0, push_ok};
            tcq_rp_r   <= rp_nxt;
            tcq_cnt_r  <= cnt_nxt;
            tc_valid_r <= (cnt_nxt != 4'h0);
            tc_entry_r <= head_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // suspend detect and resume wake; line level is already synchronous
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            idle_cnt_r <= 17'h00000;
            sleep_ok_r <= 1'b0;
            wake_r     <= 1'b0;
            link_ls_r  <= 1'b0;
            clk_sel_r  <= 2'h0;
        end else begin
            wake_r    <= sleep_ok_r && !line_idle;
            link_ls_r <= low_speed;
            clk_sel_r <= clk_src_sel;
            if (!line_idle) begin
                idle_cnt_r <= 17'h00000;
                sleep_ok_r <= 1'b0;
            end else if (idle_cnt_r == SUSP_LAST) begin
                sleep_ok_r <= 1'b1;
            end else begin
                idle_cnt_r <= idle_cnt_r + 17'h00001;
            end
        end
    end

    assign rx_ready    = rx_ready_r;
    assign tx_o        = tx_r;
    assign hs_o        = hs_r;
    assign mem_req     = mem_req_r;
    assign mem_we      = mem_we_r;
    assign mem_addr    = mem_addr_r;
    assign mem_wdata   = mem_wdata_r;
    assign tc_valid    = tc_valid_r;
    assign tc_entry    = tc_entry_r;
    assign evt_tc      = evt_tc_r;
    assign evt_setup   = evt_setup_r;
    assign sleep_ok    = sleep_ok_r;
    assign wake        = wake_r;
    assign link_ls     = link_ls_r;
    assign usb_clk_sel = clk_sel_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_fetch_adr;
        @(posedge core_clk) disable iff (sys_rst)
        (st_r == S_FETCH && mem_req_r) |->
            mem_addr_r == desc_base + {8'h00, tok_r.ep, slot_r, idx_r};
    endproperty
    a_fetch_adr: assert property (p_fetch_adr)
        else $error("descriptor fetch address wrong");

    property p_fetch_end;
        @(posedge core_clk) disable iff (sys_rst)
        (st_r == S_FETCH && ack && idx_r == DESC_LAST) |=> st_r == S_DEC;
    endproperty
    a_fetch_end: assert property (p_fetch_end)
        else $error("fetch did not stop after last byte");

    property p_len_cap;
        @(posedge core_clk) disable iff (sys_rst)
        (tx_r.valid && !tx_r.empty) |-> off_r < maxp;
    endproperty
    a_len_cap: assert property (p_len_cap)
        else $error("in packet longer than max payload");

    property p_mp_quiet;
        @(posedge core_clk) disable iff (sys_rst)
        (wb_end && mp && !short_pk && cnt_new != 10'h000) |=> !evt_tc_r;
    endproperty
    a_mp_quiet: assert property (p_mp_quiet)
        else $error("completion on mid multi-packet");

    property p_tc_push;
        @(posedge core_clk) disable iff (sys_rst)
        push_ok |=> tc_valid_r ##0 evt_tc_r;
    endproperty
    a_tc_push: assert property (p_tc_push)
        else $error("completion not queued");

    property p_pp_flip;
        @(posedge core_clk) disable iff (sys_rst)
        (wb_end && pp_en[tok_r.ep]) |=> bank_r != $past(bank_r);
    endproperty
    a_pp_flip: assert property (p_pp_flip)
        else $error("bank did not flip");

    property p_wake;
        @(posedge core_clk) disable iff (sys_rst)
        (sleep_ok_r && !line_idle) |=> (wake_r && !sleep_ok_r) ##1 !wake_r;
    endproperty
    a_wake: assert property (p_wake)
        else $error("resume wake missing");

    property p_setup_tgl;
        @(posedge core_clk) disable iff (sys_rst)
        (st_r == S_WB && is_setup && idx_r == D_CTRL && mem_req_r)
            |-> mem_wdata_r[CF_TGL];
    endproperty
    a_setup_tgl: assert property (p_setup_tgl)
        else $error("setup did not set next toggle");

endmodule

`default_nettype wire

// >>> verification/ueng_sram_model.sv
// Purpose: byte sram answering the engine's memory port
// Assumes: one request at a time, held until acknowledged
// Notes  : random 1 to 3 cycle wait, so both quick and slow answers occur
`timescale 1ns/100ps
`default_nettype none
module ueng_sram_model (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic             mem_ack,
    output logic [7:0]       mem_rdata,
    output logic [15:0]      wr_cnt
);
    logic [7:0] mem [0:65535];
    int         wait_r;
    ////////////////////////////////////////////////////////////////////
    // read data is scrambled outside the ack cycle so stale bytes show
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_ack <= 1'b0;
            wait_r <= 0;
            wr_cnt <= 16'h0000;
            mem_rdata <= 8'h00;
        end else if (mem_ack || !mem_req) begin
            mem_ack <= 1'b0;
            wait_r <= $urandom_range(2, 0);
            mem_rdata <= ~mem_rdata;
        end else if (wait_r != 0) begin
            wait_r <= wait_r - 1;
            mem_rdata <= ~mem_rdata;
        end else begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr];
            if (mem_we) begin
                mem[mem_addr] <= mem_wdata;
                wr_cnt <= wr_cnt + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/usb_device_endpoint_engine_tb.sv
// Purpose: self-checking bench for the usb endpoint engine
// Assumes: sram model on memory port, bench plays the link side
// Notes  : suspend idle time shortened to 20 cycles
`timescale 1ns/100ps
`default_nettype none
module usb_device_endpoint_engine_tb import ueng_pkg::*;;
    localparam logic [15:0] DB = 16'h1000;
    logic core_clk = 0, sys_rst = 1, low_speed = 0, rx_valid = 0;
    logic rx_end = 0, tx_ready = 0, in_ack = 0, in_fail = 0, tc_pop = 0;
    logic line_idle = 0, rx_ready, mem_req, mem_we, mem_ack, tc_valid;
    logic evt_tc, evt_setup, sleep_ok, wake, link_ls;
    logic [1:0] clk_src_sel = 2'h0, usb_clk_sel;
    logic [15:0] desc_base = DB, pp_en = 16'h0002, mem_addr, wr_cnt;
    logic [15:0] bank_m = 16'h0000;
    logic [7:0] rx_data = 8'h00, mem_wdata, mem_rdata;
    ueng_tok_t tok_i = '0;
    ueng_tx_t tx_o;
    ueng_hs_t hs_o;
    ueng_tc_t tc_entry;
    ueng_tx_t txq[$];
    logic [5:0] tcq[$];
    int n_errors = 0, check_count = 0, cyc = 0, n_push = 0;
    int n_hs = 0, n_stall = 0, n_tc = 0, n_setup = 0, n_wake = 0;
    ueng_core #(.SUSP_CYC(20)) u_dut (.*);
    ueng_sram_model u_mem (.*);
    ////////////////////////////////////////////////////////////////////
    // 25 MHz keeps the core above the full speed minimum
    always #20 core_clk = ~core_clk;
    // random stalls on the in stream, changed off the sampling edge
    always @(negedge core_clk) tx_ready = $urandom_range(1, 0);
    // pulse counters and in byte capture; hang guard last
    always @(posedge core_clk) begin
        cyc++;
        if (hs_o.valid && !hs_o.stall) n_hs++;
        if (hs_o.valid && hs_o.stall) n_stall++;
        if (evt_tc) n_tc++;
        if (evt_setup) n_setup++;
        if (wake) n_wake++;
        if (tx_o.valid && tx_ready) txq.push_back(tx_o);
        if (cyc > 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // write-back is done once the sram has taken the expected writes
    task automatic wait_wr(input logic [15:0] n);
        int k;
        k = 0;
        while (wr_cnt < n && k < 900) begin
            @(negedge core_clk);
            k++;
        end
        chk(wr_cnt, n);
        repeat (2) @(negedge core_clk);
    endtask
    task automatic wait_rdy;
        int k;
        k = 0;
        while (rx_ready !== 1'b1 && k < 300) begin
            @(negedge core_clk);
            k++;
        end
    endtask
    task automatic tok(input ueng_pid_t k, input logic [3:0] ep);
        tok_i = '{1'b1, k, ep};
        @(negedge core_clk);
        tok_i = '0;
    endtask
    task automatic set_desc(input logic [3:0] ep, input logic sl,
        input logic [7:0] c, input logic [15:0] mx, p, n);
        logic [55:0] b;
        b = {n, p, mx, c};
        for (int i = 0; i < 7; i++) u_mem.mem[DB + {ep, sl, 3'h0} + i] =
            b[8*i +: 8];
    endtask
    task automatic in_xfer(input logic [3:0] ep, input logic [7:0] c,
        input logic [15:0] mx, p, n);
        logic [15:0] len, w0, a;
        logic sl, iso;
        sl = pp_en[ep] ? bank_m[ep] : 1'b1;
        a = DB + {ep, sl, 3'h0};
        iso = (c[7:6] == 2'h3);
        len = (n < mx) ? n : mx;
        set_desc(ep, sl, c, mx, p, n);
        for (int i = 0; i < len; i++) u_mem.mem[p + i] = $urandom;
        txq.delete();
        w0 = wr_cnt;
        tok(PID_IN, ep);
        for (int k = 0; k < 900 && txq.size() < len + (len == 0); k++)
            @(negedge core_clk);
        for (int i = 0; i < len; i++) chk({txq[i].last, txq[i].data1,
            txq[i].data}, {i == len - 1, c[0], u_mem.mem[p + i]});
        chk(txq[0].empty, len == 0);
        if (!iso) begin
            in_ack = 1'b1;
            @(negedge core_clk);
            in_ack = 1'b0;
        end
        wait_wr(w0 + 16'h0007);
        chk(u_mem.mem[a], {c[7:1], c[0] ^ !iso});
        chk({u_mem.mem[a+4], u_mem.mem[a+3]}, c[4] ? p + len : p);
        chk({u_mem.mem[a+6], u_mem.mem[a+5]}, c[4] ? n - len : n);
        if (!c[4] || len < mx || n == len) tcq.push_back({ep, 1'b1, sl});
        if (pp_en[ep]) bank_m[ep] = ~bank_m[ep];
    endtask
    task automatic out_xfer(input ueng_pid_t k, input logic [3:0] ep,
        input logic [7:0] c, input logic [15:0] mx, p, input int n);
        logic [15:0] st, w0, a;
        logic [7:0] d[$];
        logic sl;
        int h0, s0, t0;
        sl = pp_en[ep] ? bank_m[ep] : 1'b0;
        a = DB + {ep, sl, 3'h0};
        st = (n < mx) ? n : mx;
        set_desc(ep, sl, c, mx, p, 16'h0000);
        for (int i = 0; i <= n; i++) u_mem.mem[p + i] = 8'hEE;
        h0 = n_hs;
        s0 = n_setup;
        t0 = n_stall;
        w0 = wr_cnt;
        tok(k, ep);
        for (int i = 0; i < n; i++) begin
            d.push_back($urandom);
            wait_rdy();
            rx_valid = 1'b1;
            rx_data = d[i];
            @(negedge core_clk);
            rx_valid = 1'b0;
            @(negedge core_clk);
        end
        wait_rdy();
        rx_end = 1'b1;
        @(negedge core_clk);
        rx_end = 1'b0;
        wait_wr(w0 + st + 16'h0007);
        for (int i = 0; i < st; i++) chk(u_mem.mem[p + i], d[i]);
        chk(u_mem.mem[p + st], 8'hEE);
        chk(u_mem.mem[a + 5], st[7:0]);
        chk(16'(n_hs - h0), {15'h0, c[7:6] != 2'h3});
        chk(16'(n_stall - t0), 16'h0000);
        chk(n_setup - s0, k == PID_SETUP);
        tcq.push_back({ep, 1'b0, sl});
        if (pp_en[ep]) bank_m[ep] = ~bank_m[ep];
    endtask
    ////////////////////////////////////////////////////////////////////
    // main sequence: reset, mirrors, every transfer type, stall, queue
    initial begin
        void'($urandom(32'h71de78a5));
        repeat (10) @(negedge core_clk);
        chk({tx_o, hs_o}, 16'h0000);
        chk({mem_req, tc_valid, sleep_ok, wake, evt_tc}, 16'h0000);
        repeat (10) @(negedge core_clk);
        sys_rst = 1'b0;
        low_speed = 1'b1;
        clk_src_sel = $urandom;
        repeat (2) @(negedge core_clk);
        chk(link_ls, 1'b1);
        chk(usb_clk_sel, clk_src_sel);
        in_xfer(4'h3, 8'h80, 16'h0008, 16'h2100, 16'h0005);
        in_xfer(4'h4, 8'h90, 16'h0004, 16'h2200, 16'h000A);
        in_xfer(4'h4, 8'h91, 16'h0004, 16'h2204, 16'h0006);
        in_xfer(4'h4, 8'h90, 16'h0004, 16'h2208, 16'h0002);
        in_xfer(4'h7, 8'hC0, 16'h0008, 16'h2300, 16'h0003);
        in_xfer(4'h5, 8'h40, 16'h0008, 16'h2900, 16'h0000);
        out_xfer(PID_SETUP, 4'h0, 8'h00, 16'h0008, 16'h2400, 8);
        out_xfer(PID_OUT, 4'h2, 8'h40, 16'h0004, 16'h2500, 5);
        out_xfer(PID_OUT, 4'h1, 8'h80, 16'h0008, 16'h2600, 3);
        out_xfer(PID_OUT, 4'h1, 8'h80, 16'h0008, 16'h2700, 2);
        // stalled endpoint answers without data and writes nothing back
        set_desc(4'h6, 1'b0, 8'h88, 16'h0008, 16'h2800, 16'h0000);
        n_push = n_stall;
        tok(PID_OUT, 4'h6);
        repeat (40) @(negedge core_clk);
        chk(16'(n_stall - n_push), 16'h0001);
        chk(wr_cnt, 16'h0057);
        chk(n_tc, tcq.size());
        while (tcq.size() > 0) begin
            chk({tc_valid, tc_entry}, {1'b1, tcq.pop_front()});
            tc_pop = 1'b1;
            @(negedge core_clk);
            tc_pop = 1'b0;
            @(negedge core_clk);
        end
        chk(tc_valid, 1'b0);
        line_idle = 1'b1;
        repeat (15) @(negedge core_clk);
        chk(sleep_ok, 1'b0);
        repeat (10) @(negedge core_clk);
        chk(sleep_ok, 1'b1);
        line_idle = 1'b0;
        repeat (3) @(negedge core_clk);
        chk({n_wake, sleep_ok}, {1'b1, 1'b0});
        print_verdict();
    end
endmodule
`default_nettype wire
